// *** ccr_top.sv ***
// three-channel control register bank with per-channel datapath
// assumes a decoded host register port on the reference clock and
// line-side pins from other clocks, synchronised here
// one strobe per cycle; a read and a write together read the old word
// channel control copies only; other per-channel registers live elsewhere
//
// Summary of operation
// - one 8-bit register per channel, three offsets
// - bits 7-6 read zero, all reset zero
// - bit 5 turns generator and checker together
// - pattern replaces system transmit data
// - dual rail pattern errors on negative output
// - pattern only usable in host mode
// - local/remote bits pick one of four loops
// - bit 2 set selects e3 rate
// - bit 1 picks sts-1 or ds3 otherwise
// - bit 0 set: single rail, codecs on
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_host_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [2:0] i_tx_pos_data_in,
  input wire logic [2:0] i_tx_neg_data_in,
  input wire logic [2:0] i_rx_pos,
  input wire logic [2:0] i_rx_neg,
  input wire logic [2:0] i_lcv,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic [2:0] o_tx_pos,
  output logic [2:0] o_tx_neg,
  output logic [2:0] o_neg_rail_violation_out,
  output logic [5:0] o_rate,
  output logic [5:0] o_loop_mode,
  output logic [2:0] o_codec_en
);
  // pin synchronisers: stage one is read only by stage two
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic [15:0] pin_raw;

  // stage-two views of each pin group
  logic host_mode_s;
  logic [2:0] txp_s;
  logic [2:0] txn_s;
  logic [2:0] rxp_s;
  logic [2:0] rxn_s;
  logic [2:0] lcv_s;

  // register copies and host decode
  logic [7:0] ctl_q [3];
  logic [2:0] hit;
  logic [2:0] wr_en;
  logic [7:0] wr_word;
  logic [7:0] rd_mux;
  logic [7:0] rd_word;
  logic any_strobe;

  // all line-side pins travel as one word through the sync stages
  assign pin_raw = {i_host_mode, i_tx_pos_data_in, i_tx_neg_data_in,
                    i_rx_pos, i_rx_neg, i_lcv};

  // logic reads stage two only; stage one may still be settling
  assign host_mode_s = pin_s2_q[15];
  assign txp_s = pin_s2_q[14:12];
  assign txn_s = pin_s2_q[11:9];
  assign rxp_s = pin_s2_q[8:6];
  assign rxn_s = pin_s2_q[5:3];
  assign lcv_s = pin_s2_q[2:0];

  // first sync stage, fed straight from the pins
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_s1_q <= 16'h0000;
    else
      pin_s1_q <= pin_raw;
  end

  // second sync stage, the only reader of stage one
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_s2_q <= 16'h0000;
    else
      pin_s2_q <= pin_s1_q;
  end

  // offset of each channel's copy
  function automatic logic [7:0] ch_offset(input int ch);
    case (ch)
      0: ch_offset = `CCR_OFS_CH0;
      1: ch_offset = `CCR_OFS_CH1;
      default: ch_offset = `CCR_OFS_CH2;
    endcase
  endfunction

  // read data: unmapped offsets answer zero
  assign rd_mux = hit[0] ? ctl_q[0]
                : hit[1] ? ctl_q[1]
                : hit[2] ? ctl_q[2]
                : 8'h00;

  // read word stands only with the strobe, so idle cycles show zero
  // a write in the same cycle lands later, so the old word is read
  assign rd_word = i_reg_rd ? rd_mux : 8'h00;
  // every strobe is answered, mapped or not, so a host never stalls
  assign any_strobe = i_reg_rd | i_reg_wr;
  // reserved bits are dropped before they can store
  assign wr_word = i_reg_wdata & `CCR_RW_MASK;

  // registered read data, one cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else
      o_reg_rdata <= rd_word;
  end

  // registered acknowledge, one cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_ack <= 1'b0;
    else
      o_reg_ack <= any_strobe;
  end

  // one register, decode and datapath per channel
  genvar g;
  generate
    for (g = 0; g < `CCR_NUM_CH; g++)
    begin : g_ch
      ccr_ctrl_if ctrl ();
      ccr_pkg::ccr_rate_type rate;
      ccr_pkg::ccr_loop_type loop;
      logic pat_req;

      // address compare against this channel's offset
      assign hit[g] = (i_reg_addr == ch_offset(g));
      // a write lands only on the copy it addresses
      assign wr_en[g] = i_reg_wr & hit[g];

      // control register: reserved bits never store
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          ctl_q[g] <= `CCR_RST_VAL;
        else if (wr_en[g])
          ctl_q[g] <= wr_word;
      end

      // software request, taken before the host-mode gate
      assign pat_req = ctl_q[g][`CCR_BIT_PRBS];
      // pins-only mode keeps the pattern logic unreachable
      assign ctrl.prbs_en = pat_req & host_mode_s;
      // remaining fields pass straight through
      assign ctrl.remote_loop_sel = ctl_q[g][`CCR_BIT_REMOTE];
      assign ctrl.local_loop_sel = ctl_q[g][`CCR_BIT_LOCAL];
      assign ctrl.rate_e3_sel = ctl_q[g][`CCR_BIT_E3];
      assign ctrl.sonet_or_ds3_sel = ctl_q[g][`CCR_BIT_SONET];
      assign ctrl.rail_mode_sel = ctl_q[g][`CCR_BIT_RAIL];

      // e3 overrides the sts-1/ds3 bit
      assign rate = ctrl.rate_e3_sel ? ccr_pkg::CCR_RATE_E3
                  : (ctrl.sonet_or_ds3_sel ? ccr_pkg::CCR_RATE_STS1
                                           : ccr_pkg::CCR_RATE_DS3);
      // loop code is {local, remote}, the reverse of their order in the register
      assign loop = ccr_pkg::ccr_loop_type'({ctrl.local_loop_sel,
                                             ctrl.remote_loop_sel});

      // rate code goes out registered
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          o_rate[2*g+:2] <= 2'h0;
        else
          o_rate[2*g+:2] <= rate;
      end

      // loop code goes out registered
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          o_loop_mode[2*g+:2] <= 2'h0;
        else
          o_loop_mode[2*g+:2] <= loop;
      end

      // codec enable follows the rail select; dual rail keeps codecs off
      always_ff @(posedge i_ref_clk or posedge i_rst)
      begin
        if (i_rst)
          o_codec_en[g] <= 1'b0;
        else
          o_codec_en[g] <= ctrl.rail_mode_sel;
      end

      // channel datapath sees only its own control fields
      ccr_chan u_chan (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .ctrl(ctrl),
        .i_tx_pos(txp_s[g]),
        .i_tx_neg(txn_s[g]),
        .i_rx_pos(rxp_s[g]),
        .i_rx_neg(rxn_s[g]),
        .i_lcv(lcv_s[g]),
        .o_tx_pos(o_tx_pos[g]),
        .o_tx_neg(o_tx_neg[g]),
        .o_neg_out(o_neg_rail_violation_out[g])
      );
    end
  endgenerate
endmodule

// *** ccr_map.svh ***
// offsets, field positions, reset values and pattern constants of the
// per-channel control register bank; definitions only
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

`define CCR_NUM_CH 3
`define CCR_OFS_CH0 8'h06
`define CCR_OFS_CH1 8'h0E
`define CCR_OFS_CH2 8'h16
`define CCR_RST_VAL 8'h00
`define CCR_RW_MASK 8'h3F
`define CCR_BIT_RAIL 0
`define CCR_BIT_SONET 1
`define CCR_BIT_E3 2
`define CCR_BIT_LOCAL 3
`define CCR_BIT_REMOTE 4
`define CCR_BIT_PRBS 5
// pattern lengths and second taps (first tap is the top stage)
`define CCR_PRBS_LEN_SHORT 15
`define CCR_PRBS_TAP_SHORT 14
`define CCR_PRBS_LEN_LONG 23
`define CCR_PRBS_TAP_LONG 18
`define CCR_PRBS_SEED 23'h7FFFFF

`endif

// *** ccr_pkg.sv ***
// types shared by the control register bank and its channel datapath
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_RATE_DS3 = 2'b00,
    CCR_RATE_STS1 = 2'b01,
    CCR_RATE_E3 = 2'b10
  } ccr_rate_type;

  typedef enum logic [1:0] {
    CCR_LOOP_NORMAL = 2'b00,
    CCR_LOOP_REMOTE = 2'b01,
    CCR_LOOP_ANALOG_LOCAL = 2'b10,
    CCR_LOOP_DIGITAL_LOCAL = 2'b11
  } ccr_loop_type;
endpackage

// *** ccr_ctrl_if.sv ***
// control fields handed from the register bank to one channel datapath
// assumes both ends run on the same reference clock
`timescale 1ns/1ps
interface ccr_ctrl_if;
  logic prbs_en;
  logic remote_loop_sel;
  logic local_loop_sel;
  logic rate_e3_sel;
  logic sonet_or_ds3_sel;
  logic rail_mode_sel;

  modport bank (
    output prbs_en, remote_loop_sel, local_loop_sel,
    output rate_e3_sel, sonet_or_ds3_sel, rail_mode_sel
  );
  modport chan (
    input prbs_en, remote_loop_sel, local_loop_sel,
    input rate_e3_sel, sonet_or_ds3_sel, rail_mode_sel
  );
endinterface

// *** ccr_chan.sv ***
// one channel: pattern generator, pattern checker, transmit select and
// negative-rail output select; inputs arrive already synchronised
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_chan (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  ccr_ctrl_if.chan ctrl,
  input wire logic i_tx_pos,
  input wire logic i_tx_neg,
  input wire logic i_rx_pos,
  input wire logic i_rx_neg,
  input wire logic i_lcv,
  output logic o_tx_pos,
  output logic o_tx_neg,
  output logic o_neg_out
);
  logic [22:0] gen_q;
  logic [22:0] gen_d;
  logic [22:0] chk_q;
  logic [22:0] chk_d;
  logic gen_fb;
  logic chk_exp;
  logic chk_err;
  logic tx_pos_d;
  logic tx_neg_d;
  logic neg_d;

  // e3 runs the long pattern, ds3 and sts-1 the short one
  function automatic logic prbs_fb(input logic [22:0] sr, input logic long_sel);
    prbs_fb = long_sel ? (sr[`CCR_PRBS_LEN_LONG-1] ^ sr[`CCR_PRBS_TAP_LONG-1])
                       : (sr[`CCR_PRBS_LEN_SHORT-1] ^ sr[`CCR_PRBS_TAP_SHORT-1]);
  endfunction

  // generator and self-synchronising checker share the feedback function
  assign gen_fb = prbs_fb(gen_q, ctrl.rate_e3_sel);
  assign chk_exp = prbs_fb(chk_q, ctrl.rate_e3_sel);
  assign chk_err = ctrl.prbs_en & (i_rx_pos ^ chk_exp);
  // generator never settles at all zeros: reseed when off
  assign gen_d = ctrl.prbs_en ? {gen_q[21:0], gen_fb} : `CCR_PRBS_SEED;
  assign chk_d = ctrl.prbs_en ? {chk_q[21:0], i_rx_pos} : 23'h000000;

  // pattern overwrites system data on both rails
  assign tx_pos_d = ctrl.prbs_en ? gen_fb : i_tx_pos;
  assign tx_neg_d = ctrl.prbs_en ? 1'b0 : (i_tx_neg & ~ctrl.rail_mode_sel);

  // single rail: violation flag; dual rail: error flag or negative data
  assign neg_d = ctrl.rail_mode_sel ? i_lcv
               : (ctrl.prbs_en ? chk_err : i_rx_neg);

  // datapath registers follow the control fields on the next edge
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gen_q <= `CCR_PRBS_SEED;
      chk_q <= 23'h000000;
      o_tx_pos <= 1'b0;
      o_tx_neg <= 1'b0;
      o_neg_out <= 1'b0;
    end
    else
    begin
      gen_q <= gen_d;
      chk_q <= chk_d;
      o_tx_pos <= tx_pos_d;
      o_tx_neg <= tx_neg_d;
      o_neg_out <= neg_d;
    end
  end
endmodule

// *** ccr_asserts.sv ***
// port checker for the control register bank, bound into the top
// assumes one clock and an async active high reset
`timescale 1ns/1ps
module ccr_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_host_mode,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [2:0] i_tx_pos_data_in,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_ack,
  input wire logic [2:0] o_tx_pos,
  input wire logic [2:0] o_tx_neg,
  input wire logic [5:0] o_rate,
  input wire logic [5:0] o_loop_mode,
  input wire logic [2:0] o_codec_en
);
  logic [7:0] ctl_q;
  wire w0 = i_reg_wr && i_reg_addr == 8'h06;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // own copy of channel 0, so read-back is judged, not echoed
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      ctl_q <= 8'h00;
    else if (w0)
      ctl_q <= i_reg_wdata & 8'h3F;
  end
  property p_ack; (i_reg_wr || i_reg_rd) |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_rd; i_reg_rd && i_reg_addr == 8'h06 |=> o_reg_rdata == $past(ctl_q); endproperty
  a_rd: assert property (p_rd) else $error("read back wrong");
  property p_gap; i_reg_rd && !(i_reg_addr inside {8'h06, 8'h0E, 8'h16}) |=>
    o_reg_rdata == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  property p_e3; w0 && i_reg_wdata[2] |=> ##1 o_rate[1:0] == 2'h2; endproperty
  a_e3: assert property (p_e3) else $error("e3 rate");
  property p_ds; w0 && !i_reg_wdata[2] |=> ##1 o_rate[1:0] == {1'b0, $past(i_reg_wdata[1], 2)};
  endproperty
  a_ds: assert property (p_ds) else $error("ds3 or sts1 rate");
  property p_loop; w0 |=> ##1 o_loop_mode[1:0] == {$past(i_reg_wdata[3], 2),
    $past(i_reg_wdata[4], 2)} && o_codec_en[0] == $past(i_reg_wdata[0], 2); endproperty
  a_loop: assert property (p_loop) else $error("loop or codec");
  // pattern owns the line, so the negative rail stays quiet
  property p_pat; (ctl_q[5] && i_host_mode) [*4] |-> o_tx_neg[0] == 1'b0; endproperty
  a_pat: assert property (p_pat) else $error("neg tx in pattern");
  property p_pins; !i_host_mode [*5] |-> o_tx_pos == $past(i_tx_pos_data_in, 3); endproperty
  a_pins: assert property (p_pins) else $error("pins mode tx");
  c_e3: cover property (w0 && i_reg_wdata[2]);
  c_pat: cover property (ctl_q[5] && i_host_mode && !ctl_q[0]);
  c_pins: cover property (!i_host_mode && ctl_q[5]);
endmodule
bind ccr_top ccr_asserts chk_u (.*);

// *** ccr_far.sv ***
// far side: system framer data, line looped back, error tally
// assumes the bench pulses i_clr before reading the tally
`timescale 1ns/1ps
module ccr_far (
  input wire logic i_ref_clk,
  input wire logic i_clr,
  input wire logic i_inj,
  input wire logic [2:0] i_line,
  input wire logic i_err,
  output logic [2:0] o_tpos,
  output logic [2:0] o_tneg,
  output logic [2:0] o_rpos,
  output logic [15:0] o_err_cnt
);
  logic [5:0] cnt_q = 6'h00;
  // data walks every cycle so a stale value never passes
  assign o_tpos = cnt_q[2:0];
  assign o_tneg = cnt_q[5:3];
  assign o_rpos = i_line ^ {2'h0, i_inj}; // inject flips channel 0
  // device has no counter, so pulses are counted here
  always @(posedge i_ref_clk)
  begin
    cnt_q <= #1 cnt_q + 6'h25;
    o_err_cnt <= #1 i_clr ? 16'h0000 : o_err_cnt + {15'h0000, i_err};
  end
endmodule

// *** tb_channel_control_register.sv ***
// self-checking bench for the control register bank
// assumes ccr_far as the far side of all channels
`timescale 1ns/1ps
module tb_channel_control_register;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_host_mode = 1'b1, clr = 1'b0, inj = 1'b0;
  logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, o_reg_ack;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [2:0] i_tx_pos_data_in, i_tx_neg_data_in, i_rx_pos, o_tx_pos, o_tx_neg;
  logic [2:0] o_neg_rail_violation_out, o_codec_en;
  logic [5:0] o_rate, o_loop_mode;
  logic [15:0] errs;
  logic [2:0] tp, tn;
  wire logic [2:0] i_rx_neg = i_tx_neg_data_in;
  wire logic [2:0] i_lcv = i_tx_pos_data_in;
  int fail_count = 0, n_compared = 0, i;
  always #5 i_ref_clk = ~i_ref_clk;
  ccr_top dut_u (.*);
  ccr_far far_u (.i_ref_clk(i_ref_clk), .i_clr(clr), .i_inj(inj), .i_line(o_tx_pos),
    .i_err(o_neg_rail_violation_out[0]), .o_tpos(i_tx_pos_data_in),
    .o_tneg(i_tx_neg_data_in), .o_rpos(i_rx_pos), .o_err_cnt(errs));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one strobe; answer stands only in the next cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1 i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = w;
    i_reg_rd = !w;
    @(posedge i_ref_clk);
    #1 i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    chk("ack", 8'h01, {7'h00, o_reg_ack});
    if (!w)
      chk("rdata", d, o_reg_rdata);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    // reset value, then top bits refuse writes
    for (i = 0; i < 6; i++)
      acc(1'b0, 8'h06 + 8'(i % 3 * 8), 8'h00);
    acc(1'b1, 8'h06, 8'hFF);
    acc(1'b1, 8'h0E, 8'hFF);
    acc(1'b1, 8'h16, 8'hFF);
    for (i = 0; i < 3; i++)
      acc(1'b0, 8'h06 + 8'(i * 8), 8'h3F);
    chk("rate", 8'h2A, {2'h0, o_rate});
    chk("loop", 8'h3F, {2'h0, o_loop_mode});
    chk("codec", 8'h07, {5'h00, o_codec_en});
    acc(1'b1, 8'h07, 8'hFF);
    acc(1'b0, 8'h07, 8'h00);
    // every rate, loop and rail code on channel 1
    for (i = 0; i < 32; i++)
    begin
      acc(1'b1, 8'h0E, 8'(i));
      #10;
      chk("rate1", i[2] ? 8'h02 : {7'h00, i[1]}, {6'h00, o_rate[3:2]});
      chk("loop1", {6'h00, i[3], i[4]}, {6'h00, o_loop_mode[3:2]});
      chk("codec1", {7'h00, i[0]}, {7'h00, o_codec_en[1]});
    end
    // pattern on channel 0, dual rail, line looped back
    acc(1'b1, 8'h06, 8'h20);
    repeat (100) @(posedge i_ref_clk);
    #1 clr = 1'b1;
    @(posedge i_ref_clk);
    #1 clr = 1'b0;
    repeat (300) @(posedge i_ref_clk);
    #1 chk("clean", 8'h00, errs[7:0]);
    inj = 1'b1;
    @(posedge i_ref_clk);
    #1 inj = 1'b0;
    repeat (20) @(posedge i_ref_clk);
    #1 chk("hit", 8'h01, {7'h00, errs != 16'h0000});
    // pins mode drops the pattern; data walks 5 a cycle, 3 deep
    i_host_mode = 1'b0;
    repeat (10) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("pins", {5'h00, i_tx_pos_data_in + 3'h1}, {5'h00, o_tx_pos});
    // capture the pins, then look three edges on at each rail output
    tp = i_tx_pos_data_in;
    tn = i_tx_neg_data_in;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk("txneg", {7'h00, tn[0]}, {5'h00, o_tx_neg});
    chk("negout", {5'h00, tp[2:1], tn[0]}, {5'h00, o_neg_rail_violation_out});
    give_verdict();
  end
endmodule
